// ---- hdl/mofc_pkg.sv ----
package mofc_pkg;
    // pin group shared with the motor pwm outputs
    localparam int NPIN = 6;

    // register byte offsets
    localparam logic [7:0] OFS_INVC = 8'h00;
    localparam logic [7:0] OFS_FSEL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_PINS = 8'h10;

    // inverter_control_reg_zero fields
    localparam int INVC_USE = 0;
    localparam int INVC_PWM = 1;

    // status and mask fields
    localparam int STAT_CUT = 0;
    localparam int STAT_OFF = 1;

    // pin state register fields
    localparam int PINS_LVL = 8;
    localparam int PINS_HIZ = 9;

    // reset values
    localparam logic [1:0] RST_INVC = 2'h0;
    localparam logic [5:0] RST_FSEL = 6'h00;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [1:0] RST_STAT = 2'h0;

    // cutoff latency from pin to pads
    localparam int CLK_NS = 8;
    localparam int CUT_LAT_NS = 24;
    localparam int CUT_LAT_CYC = CUT_LAT_NS / CLK_NS;
endpackage : mofc_pkg

// ---- hdl/mofc_cutoff.sv ----
module mofc_cutoff (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // cutoff pin, active low, asynchronous
    input wire logic CUTOFF_N,
    // selected peripheral function outputs, same clock
    input wire logic [5:0] FUNC_OUT,
    // pads
    output logic [5:0] PIN_O,
    output logic [5:0] PIN_OE,
    // interrupt
    output logic IRQ
);

    logic [1:0] invc_q, invc_d;
    logic [5:0] fsel_q, fsel_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [5:0] pin_o_q, pin_o_d;
    logic [5:0] pin_oe_q, pin_oe_d;
    logic irq_q, irq_d;
    logic hiz_q, hiz_d;
    logic cut_s1_q, cut_s2_q, cut_s3_q;
    logic use_b, pwm_b, hiz, wr;

    // address decode used by the error answer and its check; the read mux decodes on its own
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == mofc_pkg::OFS_INVC) || (a == mofc_pkg::OFS_FSEL) ||
                  (a == mofc_pkg::OFS_STAT) || (a == mofc_pkg::OFS_MASK) ||
                  (a == mofc_pkg::OFS_PINS);
    endfunction : reg_hit

    // two-stage synchroniser; the third stage only feeds the edge detector
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cut_s1_q <= 1'b1;
            cut_s2_q <= 1'b1;
            cut_s3_q <= 1'b1;
        end else begin
            cut_s1_q <= CUTOFF_N;
            cut_s2_q <= cut_s1_q;
            cut_s3_q <= cut_s2_q;
        end
    end

    assign use_b = invc_q[mofc_pkg::INVC_USE];
    assign pwm_b = invc_q[mofc_pkg::INVC_PWM];
    // float whenever the motor timer owns the pins and pwm is off or cut
    assign hiz = use_b && (!pwm_b || !cut_s2_q);
    assign wr = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;

    // next values for bus, registers and pads
    always_comb begin
        invc_d = invc_q;
        fsel_d = fsel_q;
        mask_d = mask_q;
        stat_d = stat_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        // setup cycle: answer is prepared so the access phase ends at once
        if (PSEL && !PENABLE) begin
            pready_d = 1'b1;
            pslverr_d = !reg_hit(PADDR);
            unique case (PADDR)
                mofc_pkg::OFS_INVC: prdata_d = {30'h0, invc_q};
                mofc_pkg::OFS_FSEL: prdata_d = {26'h0, fsel_q};
                mofc_pkg::OFS_STAT: prdata_d = {30'h0, stat_q};
                mofc_pkg::OFS_MASK: prdata_d = {30'h0, mask_q};
                mofc_pkg::OFS_PINS: prdata_d = {22'h0, hiz_q, cut_s2_q, 2'h0, pin_oe_q};
                default: prdata_d = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (PADDR)
                mofc_pkg::OFS_INVC: invc_d = PWDATA[1:0];
                mofc_pkg::OFS_FSEL: fsel_d = PWDATA[5:0];
                mofc_pkg::OFS_STAT: stat_d = stat_q & ~PWDATA[1:0];
                mofc_pkg::OFS_MASK: mask_d = PWDATA[1:0];
                default: ;
            endcase
        end
        // a low pin beats a software write of the enable bit, keeping the stage safe
        if (use_b && !cut_s2_q) begin
            invc_d[mofc_pkg::INVC_PWM] = 1'b0;
        end
        // events are set after the clear so a set in the same cycle wins
        if (!cut_s2_q && cut_s3_q) begin
            stat_d[mofc_pkg::STAT_CUT] = 1'b1;
        end
        if (use_b && pwm_b && !cut_s2_q) begin
            stat_d[mofc_pkg::STAT_OFF] = 1'b1;
        end
        // only pins in an output function are driven, others stay inputs
        pin_oe_d = fsel_q & ~{6{hiz}};
        pin_o_d = FUNC_OUT;
        hiz_d = hiz;
        irq_d = |(stat_q & mask_q);
    end

    // register stage
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            invc_q <= mofc_pkg::RST_INVC;
            fsel_q <= mofc_pkg::RST_FSEL;
            stat_q <= mofc_pkg::RST_STAT;
            mask_q <= mofc_pkg::RST_MASK;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            pin_o_q <= 6'h00;
            pin_oe_q <= 6'h00;
            hiz_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            invc_q <= invc_d;
            fsel_q <= fsel_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            hiz_q <= hiz_d;
            irq_q <= irq_d;
        end
    end

    // outputs straight from flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PIN_O = pin_o_q;
    assign PIN_OE = pin_oe_q;
    assign IRQ = irq_q;

    // checks
    property p_r01;
        @(posedge CLK) disable iff (!RST_N)
        1'b1 |=> ((PIN_OE & ~$past(fsel_q)) == 6'h00);
    endproperty
    a_r01: assert property (p_r01) else $error("non-output pin driven");

    property p_r02;
        @(posedge CLK) disable iff (!RST_N)
        !use_b |=> (PIN_OE == $past(fsel_q));
    endproperty
    a_r02: assert property (p_r02) else $error("pin not driven with timer unused");

    property p_r03;
        @(posedge CLK) disable iff (!RST_N)
        (use_b && !pwm_b) |=> (PIN_OE == 6'h00);
    endproperty
    a_r03: assert property (p_r03) else $error("pin driven with pwm disabled");

    property p_r04;
        @(posedge CLK) disable iff (!RST_N)
        (use_b && pwm_b && cut_s2_q) |=> (PIN_OE == $past(fsel_q));
    endproperty
    a_r04: assert property (p_r04) else $error("pin not driven with pin high");

    property p_r05;
        @(posedge CLK) disable iff (!RST_N)
        (use_b && pwm_b && !cut_s2_q) |=> (PIN_OE == 6'h00) && hiz_q;
    endproperty
    a_r05: assert property (p_r05) else $error("pin driven during cutoff");

    property p_r06;
        @(posedge CLK) disable iff (!RST_N)
        (use_b && !cut_s2_q) |=> !pwm_b && stat_q[mofc_pkg::STAT_OFF] == 1'b1 || !$past(pwm_b);
    endproperty
    a_r06: assert property (p_r06) else $error("pwm enable not cleared");

    sequence s_cut_held;
        (use_b && pwm_b && !CUTOFF_N) ##1 (use_b && !CUTOFF_N) [*2];
    endsequence
    property p_r07;
        @(posedge CLK) disable iff (!RST_N)
        s_cut_held |=> (PIN_OE == 6'h00);
    endproperty
    a_r07: assert property (p_r07) else $error("cutoff too slow");

    property p_irq;
        @(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (IRQ == |($past(stat_q) & $past(mask_q)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    // bus answer: zero wait states, one-cycle ready, error only with ready
    property p_rdy_after_setup;
        @(posedge CLK) disable iff (!RST_N)
        (PSEL && !PENABLE) |=> PREADY;
    endproperty
    a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("no ready after setup");

    property p_rdy_one;
        @(posedge CLK) disable iff (!RST_N)
        PREADY |=> !PREADY;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");

    property p_err_with_rdy;
        @(posedge CLK) disable iff (!RST_N)
        PSLVERR |-> PREADY;
    endproperty
    a_err_with_rdy: assert property (p_err_with_rdy) else $error("error without ready");

    property p_err_unmapped;
        @(posedge CLK) disable iff (!RST_N)
        (PSEL && !PENABLE && !reg_hit(PADDR)) |=> PSLVERR && (PRDATA == 32'h0);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");

    property p_read_ctrl;
        @(posedge CLK) disable iff (!RST_N)
        (PSEL && !PENABLE && PADDR == mofc_pkg::OFS_INVC) |=> PRDATA == {30'h0, $past(invc_q)};
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

    // register writes land at the access edge
    property p_wr_ctrl;
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == mofc_pkg::OFS_INVC && cut_s2_q) |=> invc_q == $past(PWDATA[1:0]);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");

    property p_wr_fsel;
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == mofc_pkg::OFS_FSEL) |=> fsel_q == $past(PWDATA[5:0]);
    endproperty
    a_wr_fsel: assert property (p_wr_fsel) else $error("function select write lost");

    property p_wr_mask;
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == mofc_pkg::OFS_MASK) |=> mask_q == $past(PWDATA[1:0]);
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("mask write lost");

    // with the pin high no event can set, so a one written clears its bit
    property p_w1c;
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == mofc_pkg::OFS_STAT && cut_s2_q) |=> (stat_q & $past(PWDATA[1:0])) == 2'h0;
    endproperty
    a_w1c: assert property (p_w1c) else $error("status not cleared");

    property p_cut_event;
        @(posedge CLK) disable iff (!RST_N)
        (!cut_s2_q && cut_s3_q) |=> stat_q[mofc_pkg::STAT_CUT];
    endproperty
    a_cut_event: assert property (p_cut_event) else $error("pin fall event lost");

    property p_off_event;
        @(posedge CLK) disable iff (!RST_N)
        (use_b && pwm_b && !cut_s2_q) |=> stat_q[mofc_pkg::STAT_OFF];
    endproperty
    a_off_event: assert property (p_off_event) else $error("cutoff event lost");

    // a write of the enable bit while the pin is low must not reopen the pads
    property p_clear_wins;
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == mofc_pkg::OFS_INVC && use_b && !cut_s2_q) |=> !pwm_b;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("enable reopened during cutoff");

    property p_use0_pin_ignored;
        @(posedge CLK) disable iff (!RST_N)
        (!use_b && !cut_s2_q) |=> PIN_OE == $past(fsel_q);
    endproperty
    a_use0_pin_ignored: assert property (p_use0_pin_ignored) else $error("pin acted with timer unused");

    property p_float_flag;
        @(posedge CLK) disable iff (!RST_N)
        hiz_q |-> (PIN_OE == 6'h00);
    endproperty
    a_float_flag: assert property (p_float_flag) else $error("float flag with pad driven");

    property p_sync_chain;
        @(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (cut_s2_q == $past(cut_s1_q));
    endproperty
    a_sync_chain: assert property (p_sync_chain) else $error("synchroniser stage skipped");

    property p_pad_value;
        @(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (PIN_O == $past(FUNC_OUT));
    endproperty
    a_pad_value: assert property (p_pad_value) else $error("pad value not function output");

    // two quiet cycles of status and mask leave the interrupt low
    sequence s_no_event;
        ((stat_q & mask_q) == 2'h0) ##1 ((stat_q & mask_q) == 2'h0);
    endsequence
    property p_irq_quiet;
        @(posedge CLK) disable iff (!RST_N)
        s_no_event |=> !IRQ;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without event");

endmodule : mofc_cutoff

// ---- dv/mofc_stage.sv ----
// power stage gate inputs seen through the shared pads
module mofc_stage (
    // pads from the device
    input wire logic [5:0] PIN_O,
    input wire logic [5:0] PIN_OE,
    // gate drive seen by the switches
    output logic [5:0] GATE
);
    timeunit 1ns;
    timeprecision 1ps;
    // gate inputs carry pull-downs: a floating pad switches the stage off
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            GATE[i] = PIN_OE[i] ? PIN_O[i] : 1'b0;
        end
    end
endmodule : mofc_stage

// ---- dv/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, IRQ, CUTOFF_N = 1'b1, err;
    logic [5:0] FUNC_OUT = 6'h2a, PIN_O, PIN_OE, GATE;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    mofc_cutoff i_mofc_cutoff (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CUTOFF_N(CUTOFF_N), .FUNC_OUT(FUNC_OUT), .PIN_O(PIN_O),
        .PIN_OE(PIN_OE), .IRQ(IRQ));
    mofc_stage i_mofc_stage (.PIN_O(PIN_O), .PIN_OE(PIN_OE), .GATE(GATE));
    initial begin
        forever #4 CLK = ~CLK;
    end
    // hang guard, far above the under one hundred cycles the sequence needs
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; pready is taken at the edge, before that edge's updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic pads(input logic [5:0] exp);
        repeat (2) @(posedge CLK);
        #1 chk({26'h0, PIN_OE}, {26'h0, exp});
    endtask : pads
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rchk(mofc_pkg::OFS_INVC, 32'h0);
        rchk(mofc_pkg::OFS_STAT, 32'h0);
        apb(1'b1, mofc_pkg::OFS_FSEL, 32'h3f);
        apb(1'b1, mofc_pkg::OFS_INVC, 32'h0);
        pads(6'h3f);
        chk({26'h0, PIN_O}, 32'h2a);
        CUTOFF_N <= 1'b0;
        pads(6'h3f);
        CUTOFF_N <= 1'b1;
        rchk(mofc_pkg::OFS_STAT, 32'h1);
        apb(1'b1, mofc_pkg::OFS_STAT, 32'h1);
        rchk(mofc_pkg::OFS_STAT, 32'h0);
        apb(1'b1, mofc_pkg::OFS_FSEL, 32'h0f);
        pads(6'h0f);
        apb(1'b1, mofc_pkg::OFS_INVC, 32'h1);
        pads(6'h00);
        apb(1'b1, mofc_pkg::OFS_INVC, 32'h3);
        pads(6'h0f);
        apb(1'b1, mofc_pkg::OFS_MASK, 32'h2);
        FUNC_OUT <= 6'h3f;
        @(posedge CLK);
        CUTOFF_N <= 1'b0;
        // the float must not show before the third edge
        repeat (2) @(posedge CLK);
        #1 chk({26'h0, PIN_OE}, 32'h0f);
        @(posedge CLK);
        #1 chk({26'h0, PIN_OE}, 32'h00);
        chk({26'h0, GATE}, 32'h00);
        @(posedge CLK);
        #1 chk({31'h0, IRQ}, 32'h1);
        CUTOFF_N <= 1'b1;
        rchk(mofc_pkg::OFS_INVC, 32'h1);
        pads(6'h00);
        rchk(mofc_pkg::OFS_PINS, 32'h300);
        apb(1'b1, mofc_pkg::OFS_STAT, 32'h3);
        rchk(mofc_pkg::OFS_STAT, 32'h0);
        repeat (2) @(posedge CLK);
        #1 chk({31'h0, IRQ}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, mofc_pkg::OFS_INVC, 32'h3);
        pads(6'h0f);
        end_of_test();
    end
endmodule : tb_top
